// ===== rtl/serial_port_pkg.sv
`default_nettype none
package serial_port_pkg;

  // ===========================================================
  // characters
  localparam logic [7:0] CHAR_XON  = 8'h11;
  localparam logic [7:0] CHAR_XOFF = 8'h13;
  localparam logic [7:0] CHAR_CR   = 8'h0D;
  localparam logic [7:0] CHAR_LF   = 8'h0A;
  localparam logic [7:0] CHAR_ESC  = 8'h1B;

  // ===========================================================
  // timing
  localparam int CLOCK_HZ       = 40000000;
  localparam int DEFAULT_BAUD   = 38400;
  localparam logic [15:0] DEFAULT_DIVISOR =
    16'(CLOCK_HZ / DEFAULT_BAUD);
  localparam int DATA_BITS      = 8;
  localparam int STOP_BITS      = 1;

  // ===========================================================
  // register offsets
  localparam logic [11:0] CTRL_OFFSET   = 12'h000;
  localparam logic [11:0] DIV_OFFSET    = 12'h004;
  localparam logic [11:0] STATUS_OFFSET = 12'h008;
  localparam logic [11:0] RXDATA_OFFSET = 12'h00C;
  localparam logic [11:0] DONE_OFFSET   = 12'h010;
  localparam logic [11:0] PROMPT_OFFSET = 12'h014;

  // ===========================================================
  // control fields and reset values
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_ECHO_BIT   = 1;
  localparam int CTRL_FLOW_BIT   = 2;
  localparam int CTRL_PROMPT_BIT = 3;
  localparam logic [3:0] CTRL_RESET = 4'h5;
  localparam logic [7:0] PROMPT_RESET = 8'h3E;

  typedef enum logic [2:0] {
    REPLY_IDLE   = 3'b000,
    REPLY_XOFF   = 3'b001,
    REPLY_CR     = 3'b010,
    REPLY_LF     = 3'b011,
    REPLY_WAIT   = 3'b100,
    REPLY_PROMPT = 3'b101,
    REPLY_XON    = 3'b110
  } reply_state_e;

endpackage
`default_nettype wire

// ===== rtl/char_buffer.sv
`timescale 1ns/1ps
`default_nettype none
module char_buffer (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       clock_en,
  input  wire logic       in_valid,
  output logic            in_ready,
  input  wire logic [7:0] in_data,
  output logic            out_valid,
  input  wire logic       out_ready,
  output logic      [7:0] out_data
);

  // ===========================================================
  // two-entry buffer
  logic [7:0] mem_reg [2];
  logic       wr_ptr_reg;
  logic       rd_ptr_reg;
  logic [1:0] count_reg;
  logic       push;
  logic       pop;

  assign in_ready  = (count_reg != 2'h2);
  assign out_valid = (count_reg != 2'h0);
  assign out_data  = mem_reg[rd_ptr_reg];
  assign push      = clock_en && in_valid && in_ready;
  assign pop       = clock_en && out_valid && out_ready;

  always_ff @(posedge clock) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg  <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule
`default_nettype wire

// ===== rtl/serial_command_port.sv
`timescale 1ns/1ps
`default_nettype none
module serial_command_port (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        clock_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rxd,
  output logic             txd
);

  // ===========================================================
  // control registers
  logic [3:0]  ctrl_reg;
  logic [15:0] divisor_reg;
  logic [7:0]  prompt_reg;
  logic        busy_reg;
  logic        overrun_reg;
  logic        initialised_reg;
  logic        apb_write;
  logic        done_pulse;

  assign apb_write = clock_en && psel && penable && pwrite;
  assign pready    = 1'b1;
  assign pslverr   = psel && penable &&
                     !(paddr == serial_port_pkg::CTRL_OFFSET ||
                       paddr == serial_port_pkg::DIV_OFFSET ||
                       paddr == serial_port_pkg::STATUS_OFFSET ||
                       paddr == serial_port_pkg::RXDATA_OFFSET ||
                       paddr == serial_port_pkg::DONE_OFFSET ||
                       paddr == serial_port_pkg::PROMPT_OFFSET);
  assign done_pulse = apb_write && paddr == serial_port_pkg::DONE_OFFSET;

  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_reg    <= serial_port_pkg::CTRL_RESET;
      divisor_reg <= serial_port_pkg::DEFAULT_DIVISOR;
      prompt_reg  <= serial_port_pkg::PROMPT_RESET;
    end else if (apb_write) begin
      if (paddr == serial_port_pkg::CTRL_OFFSET) begin
        ctrl_reg <= pwdata[3:0];
      end
      if (paddr == serial_port_pkg::DIV_OFFSET) begin
        divisor_reg <= pwdata[15:0];
      end
      if (paddr == serial_port_pkg::PROMPT_OFFSET) begin
        prompt_reg <= pwdata[7:0];
      end
    end
  end

  logic       echo_on;
  logic       flow_on;
  logic       port_on;
  logic       prompt_on;
  assign port_on   = ctrl_reg[serial_port_pkg::CTRL_ENABLE_BIT];
  assign echo_on   = ctrl_reg[serial_port_pkg::CTRL_ECHO_BIT];
  assign flow_on   = ctrl_reg[serial_port_pkg::CTRL_FLOW_BIT];
  assign prompt_on = ctrl_reg[serial_port_pkg::CTRL_PROMPT_BIT];

  // ===========================================================
  // input synchroniser
  logic [2:0] rx_sync_reg;
  logic       rx_level_reg;
  always_ff @(posedge clock) begin
    if (rst) begin
      rx_sync_reg  <= 3'h7;
      rx_level_reg <= 1'b1;
    end else if (clock_en) begin
      rx_sync_reg <= {rx_sync_reg[1:0], rxd};
      if (rx_sync_reg[1] == rx_sync_reg[2]) begin
        rx_level_reg <= rx_sync_reg[2];
      end
    end
  end

  // ===========================================================
  // receiver, fixed rate from divisor only
  logic [15:0] rx_count_reg;
  logic [3:0]  rx_bit_reg;
  logic [7:0]  rx_shift_reg;
  logic        rx_active_reg;
  logic        rx_strobe_reg;
  logic [7:0]  rx_char_reg;
  always_ff @(posedge clock) begin
    if (rst) begin
      rx_count_reg  <= 16'h0000;
      rx_bit_reg    <= 4'h0;
      rx_shift_reg  <= 8'h00;
      rx_active_reg <= 1'b0;
      rx_strobe_reg <= 1'b0;
      rx_char_reg   <= 8'h00;
    end else if (clock_en) begin
      rx_strobe_reg <= 1'b0;
      if (!rx_active_reg) begin
        if (!rx_level_reg && port_on) begin
          rx_active_reg <= 1'b1;
          rx_count_reg  <= {1'b0, divisor_reg[15:1]};
          rx_bit_reg    <= 4'h0;
        end
      end else if (rx_count_reg != 16'h0000) begin
        rx_count_reg <= rx_count_reg - 16'h0001;
      end else begin
        rx_count_reg <= divisor_reg - 16'h0001;
        rx_bit_reg   <= rx_bit_reg + 4'h1;
        if (rx_bit_reg == 4'h0 && rx_level_reg) begin
          rx_active_reg <= 1'b0;
        end else if (rx_bit_reg == 4'h9) begin
          rx_active_reg <= 1'b0;
          if (rx_level_reg) begin
            rx_strobe_reg <= 1'b1;
            rx_char_reg   <= rx_shift_reg;
          end
        end else if (rx_bit_reg != 4'h0) begin
          rx_shift_reg <= {rx_level_reg, rx_shift_reg[7:1]};
        end
      end
    end
  end

  logic rx_terminator;
  logic rx_init_char;
  assign rx_terminator = rx_strobe_reg &&
    (rx_char_reg == serial_port_pkg::CHAR_CR ||
     rx_char_reg == serial_port_pkg::CHAR_LF);
  assign rx_init_char = rx_strobe_reg && (rx_terminator ||
     rx_char_reg == serial_port_pkg::CHAR_ESC);

  // ===========================================================
  // received character and status
  logic [7:0] rx_hold_reg;
  always_ff @(posedge clock) begin
    if (rst) begin
      rx_hold_reg     <= 8'h00;
      overrun_reg     <= 1'b0;
      initialised_reg <= 1'b0;
    end else if (clock_en) begin
      if (rx_strobe_reg) begin
        rx_hold_reg <= rx_char_reg;
      end
      if (rx_init_char) begin
        initialised_reg <= 1'b1;
      end
      if (rx_strobe_reg && busy_reg && !rx_terminator) begin
        overrun_reg <= 1'b1;
      end else if (apb_write &&
                   paddr == serial_port_pkg::STATUS_OFFSET &&
                   pwdata[1]) begin
        overrun_reg <= 1'b0;
      end
    end
  end

  // ===========================================================
  // reply sequencer
  serial_port_pkg::reply_state_e state_reg;
  logic       q_valid;
  logic       q_ready;
  logic [7:0] q_data;
  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg <= serial_port_pkg::REPLY_XON;
      busy_reg  <= 1'b0;
    end else if (clock_en) begin
      case (state_reg)
        serial_port_pkg::REPLY_IDLE: begin
          if (rx_terminator) begin
            state_reg <= serial_port_pkg::REPLY_XOFF;
            busy_reg  <= 1'b1;
          end
        end
        serial_port_pkg::REPLY_XOFF: begin
          if (q_ready) begin
            state_reg <= echo_on ? serial_port_pkg::REPLY_CR
                                 : serial_port_pkg::REPLY_WAIT;
          end
        end
        serial_port_pkg::REPLY_CR: begin
          if (q_ready) begin
            state_reg <= serial_port_pkg::REPLY_LF;
          end
        end
        serial_port_pkg::REPLY_LF: begin
          if (q_ready) begin
            state_reg <= serial_port_pkg::REPLY_WAIT;
          end
        end
        serial_port_pkg::REPLY_WAIT: begin
          if (done_pulse) begin
            busy_reg  <= 1'b0;
            state_reg <= prompt_on ? serial_port_pkg::REPLY_PROMPT
                                   : serial_port_pkg::REPLY_XON;
          end
        end
        serial_port_pkg::REPLY_PROMPT: begin
          if (q_ready) begin
            state_reg <= serial_port_pkg::REPLY_XON;
          end
        end
        serial_port_pkg::REPLY_XON: begin
          if (q_ready || !flow_on) begin
            state_reg <= serial_port_pkg::REPLY_IDLE;
          end
        end
        default: begin
          state_reg <= serial_port_pkg::REPLY_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    q_valid = 1'b0;
    q_data  = 8'h00;
    case (state_reg)
      serial_port_pkg::REPLY_XOFF: begin
        q_valid = 1'b1;
        q_data  = flow_on ? serial_port_pkg::CHAR_XOFF
                          : serial_port_pkg::CHAR_CR;
      end
      serial_port_pkg::REPLY_CR: begin
        q_valid = 1'b1;
        q_data  = serial_port_pkg::CHAR_CR;
      end
      serial_port_pkg::REPLY_LF: begin
        q_valid = 1'b1;
        q_data  = serial_port_pkg::CHAR_LF;
      end
      serial_port_pkg::REPLY_PROMPT: begin
        q_valid = 1'b1;
        q_data  = prompt_reg;
      end
      serial_port_pkg::REPLY_XON: begin
        q_valid = flow_on;
        q_data  = serial_port_pkg::CHAR_XON;
      end
      default: begin
        q_valid = 1'b0;
        q_data  = 8'h00;
      end
    endcase
  end

  // ===========================================================
  // transmit buffer and transmitter
  logic       tx_valid;
  logic       tx_take;
  logic [7:0] tx_data;
  char_buffer u_buffer (
    .clock     (clock),
    .rst       (rst),
    .clock_en  (clock_en),
    .in_valid  (q_valid),
    .in_ready  (q_ready),
    .in_data   (q_data),
    .out_valid (tx_valid),
    .out_ready (tx_take),
    .out_data  (tx_data)
  );

  logic [15:0] tx_count_reg;
  logic [3:0]  tx_bit_reg;
  logic [9:0]  tx_shift_reg;
  logic        tx_active_reg;
  assign tx_take = !tx_active_reg && port_on;
  always_ff @(posedge clock) begin
    if (rst) begin
      tx_count_reg  <= 16'h0000;
      tx_bit_reg    <= 4'h0;
      tx_shift_reg  <= 10'h3FF;
      tx_active_reg <= 1'b0;
    end else if (clock_en) begin
      if (!tx_active_reg) begin
        if (tx_valid && tx_take) begin
          tx_shift_reg  <= {1'b1, tx_data, 1'b0};
          tx_active_reg <= 1'b1;
          tx_bit_reg    <= 4'h0;
          tx_count_reg  <= divisor_reg - 16'h0001;
        end
      end else if (tx_count_reg != 16'h0000) begin
        tx_count_reg <= tx_count_reg - 16'h0001;
      end else begin
        tx_count_reg <= divisor_reg - 16'h0001;
        tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
        tx_bit_reg   <= tx_bit_reg + 4'h1;
        if (tx_bit_reg == 4'h9) begin
          tx_active_reg <= 1'b0;
        end
      end
    end
  end
  assign txd = tx_shift_reg[0];

  // ===========================================================
  // read data
  always_ff @(posedge clock) begin
    if (rst) begin
      prdata <= 32'h00000000;
    end else if (clock_en && psel && !penable && !pwrite) begin
      case (paddr)
        serial_port_pkg::CTRL_OFFSET:   prdata <= {28'h0, ctrl_reg};
        serial_port_pkg::DIV_OFFSET:    prdata <= {16'h0, divisor_reg};
        serial_port_pkg::STATUS_OFFSET:
          prdata <= {27'h0, state_reg == serial_port_pkg::REPLY_IDLE,
                     initialised_reg, tx_active_reg, overrun_reg,
                     busy_reg};
        serial_port_pkg::RXDATA_OFFSET: prdata <= {24'h0, rx_hold_reg};
        serial_port_pkg::PROMPT_OFFSET: prdata <= {24'h0, prompt_reg};
        default:                        prdata <= 32'h00000000;
      endcase
    end
  end

endmodule
`default_nettype wire

// ===== tb/serial_command_port_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module port_checker (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        clock_en,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        txd
);
  logic [15:0] div_reg;
  logic [15:0] low_run;
  logic        mapped;
  assign mapped = paddr <= 12'h014 && paddr[1:0] == 2'h0;
  // ==========
  // divisor copy and low run length
  always_ff @(posedge clock) begin
    if (rst) div_reg <= serial_port_pkg::DEFAULT_DIVISOR;
    else if (clock_en && psel && penable && pwrite &&
             paddr == serial_port_pkg::DIV_OFFSET) div_reg <= pwdata[15:0];
  end
  always_ff @(posedge clock) begin
    if (rst || txd) low_run <= 16'h0;
    else if (clock_en) low_run <= low_run + 16'h1;
  end
  // ==========
  // properties
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_access;
    psel && penable;
  endsequence
  sequence s_launch;
    ##[1:40] $fell(txd);
  endsequence
  a_reset_state: assert property (
    $fell(rst) |-> txd && prdata == 32'h0)
    else $error("line or read data wrong after reset");
  a_xon_launch: assert property (
    $fell(rst) |-> s_launch)
    else $error("no start bit after reset");
  a_bit_length: assert property (
    $rose(txd) |-> low_run != 16'h0 && low_run % div_reg == 16'h0)
    else $error("low run not whole bit times");
  a_zero_wait: assert property (
    s_access |-> pready)
    else $error("ready low in access");
  a_unmapped_err: assert property (
    s_access ##0 !mapped |-> pslverr)
    else $error("no error for unmapped access");
  a_mapped_ok: assert property (
    s_access ##0 mapped |-> !pslverr)
    else $error("error for mapped access");
  a_err_access: assert property (
    pslverr |-> psel && penable)
    else $error("error outside access");
  a_div_readback: assert property (
    s_access ##0 (!pwrite && paddr == serial_port_pkg::DIV_OFFSET)
    |-> prdata == {16'h0, div_reg})
    else $error("divisor read back wrong");
endmodule
bind serial_command_port port_checker chk (
  .clock(clock), .rst(rst), .clock_en(clock_en), .psel(psel),
  .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .txd(txd)
);
`default_nettype wire

// ===== tb/terminal_model.sv
`timescale 1ns/1ps
`default_nettype none
module terminal_model (
  input  wire logic clock,
  input  wire logic line_in,
  output logic      line_out
);
  int         bit_cycles = int'(serial_port_pkg::DEFAULT_DIVISOR);
  logic [7:0] rx_q[$];
  logic       xon_ok = 1'b0;
  logic [7:0] ch;
  initial line_out = 1'b1;
  // ==========
  // receiver, samples mid bit
  always begin
    @(negedge line_in);
    repeat (bit_cycles / 2) @(posedge clock);
    for (int i = 0; i < 8; i++) begin
      repeat (bit_cycles) @(posedge clock);
      ch[i] = line_in;
    end
    repeat (bit_cycles) @(posedge clock);
    if (ch == 8'h11) xon_ok = 1'b1;
    else if (ch == 8'h13) xon_ok = 1'b0;
    rx_q.push_back(ch);
  end
  // ==========
  // sender, lsb first, one stop bit
  task automatic send_char(input logic [7:0] c);
    wait (xon_ok === 1'b1);
    @(posedge clock);
    line_out <= 1'b0;
    repeat (bit_cycles) @(posedge clock);
    for (int i = 0; i < 8; i++) begin
      line_out <= c[i];
      repeat (bit_cycles) @(posedge clock);
    end
    line_out <= 1'b1;
    repeat (bit_cycles) @(posedge clock);
  endtask
endmodule
`default_nettype wire

// ===== tb/serial_command_port_flow_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
module serial_command_port_flow_control_bench;
  typedef struct packed {logic [11:0] a; logic [31:0] d; logic e;} reg_s;
  typedef struct packed {
    logic [3:0] m; logic [7:0] c; logic [1:0] np; logic [23:0] pre;
    logic [1:0] nq; logic [15:0] post;
  } line_s;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        clock_en = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rxd;
  logic        txd;
  logic [31:0] rd;
  logic        er;
  int          err_total = 0;
  int          comparisons = 0;
  int          cycles = 0;
  reg_s        regs[4] = '{'{12'h000, 32'h5, 1'b0}, '{12'h004, 32'h411, 1'b0},
                           '{12'h014, 32'h3E, 1'b0}, '{12'h018, 32'h0, 1'b1}};
  line_s       lines[4] = '{'{4'h5, 8'h0D, 2'h1, 24'h130000, 2'h1, 16'h1100},
                            '{4'h7, 8'h0A, 2'h3, 24'h130D0A, 2'h1, 16'h1100},
                            '{4'hD, 8'h0D, 2'h1, 24'h130000, 2'h2, 16'h3E11},
                            '{4'h3, 8'h0D, 2'h3, 24'h0D0D0A, 2'h0, 16'h0}};
  always #12.5 clock = ~clock;
  serial_command_port dut (
    .clock(clock), .rst(rst), .clock_en(clock_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd),
    .txd(txd)
  );
  terminal_model term (.clock(clock), .line_in(txd), .line_out(rxd));
  // ==========
  // bus, compare and report tasks
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) begin
      @(posedge clock);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic take(input logic [7:0] exp);
    int n;
    n = 0;
    while (term.rx_q.size() == 0 && n < 20000) begin
      n++;
      @(posedge clock);
    end
    if (n == 20000) begin
      check("tx char", {24'h0, exp}, 32'hFFFFFFFF);
      final_report();
    end else begin
      check("tx char", {24'h0, exp}, {24'h0, term.rx_q.pop_front()});
    end
  endtask
  task automatic final_report;
    if (err_total == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 40000) begin
      err_total++;
      final_report();
    end
  end
  // ==========
  // main sequence
  initial begin
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    foreach (regs[i]) begin
      apb(1'b0, regs[i].a, 32'h0);
      check("reg read", regs[i].d, rd);
      check("reg error", {31'h0, regs[i].e}, {31'h0, er});
    end
    take(serial_port_pkg::CHAR_XON);
    apb(1'b0, serial_port_pkg::STATUS_OFFSET, 32'h0);
    check("initialised", 32'h0, {31'h0, rd[3]});
    repeat (800) @(posedge clock);
    apb(1'b1, serial_port_pkg::DIV_OFFSET, 32'h10);
    term.bit_cycles = 16;
    apb(1'b1, 12'h020, 32'hF);
    check("unmapped error", 32'h1, {31'h0, er});
    apb(1'b0, serial_port_pkg::CTRL_OFFSET, 32'h0);
    check("ctrl kept", 32'h5, rd);
    term.send_char(8'h41);
    repeat (40) @(posedge clock);
    apb(1'b0, serial_port_pkg::RXDATA_OFFSET, 32'h0);
    check("rx data", 32'h41, rd);
    term.send_char(serial_port_pkg::CHAR_ESC);
    repeat (40) @(posedge clock);
    apb(1'b0, serial_port_pkg::STATUS_OFFSET, 32'h0);
    check("initialised", 32'h1, {31'h0, rd[3]});
    check("extra chars", 32'h0, 32'(term.rx_q.size()));
    foreach (lines[i]) begin
      apb(1'b1, serial_port_pkg::CTRL_OFFSET, {28'h0, lines[i].m});
      term.send_char(lines[i].c);
      for (int k = 0; k < lines[i].np; k++)
        take(lines[i].pre[23 - 8 * k -: 8]);
      apb(1'b1, serial_port_pkg::DONE_OFFSET, 32'h1);
      for (int k = 0; k < lines[i].nq; k++)
        take(lines[i].post[15 - 8 * k -: 8]);
      repeat (400) @(posedge clock);
      check("extra chars", 32'h0, 32'(term.rx_q.size()));
    end
    // ==========
    // frozen clock enable, then reset in mid run
    clock_en <= 1'b0;
    apb(1'b1, serial_port_pkg::PROMPT_OFFSET, 32'h21);
    clock_en <= 1'b1;
    apb(1'b0, serial_port_pkg::PROMPT_OFFSET, 32'h0);
    check("frozen prompt", {24'h0, serial_port_pkg::PROMPT_RESET}, rd);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    term.bit_cycles = int'(serial_port_pkg::DEFAULT_DIVISOR);
    apb(1'b0, serial_port_pkg::CTRL_OFFSET, 32'h0);
    check("ctrl after reset", {28'h0, serial_port_pkg::CTRL_RESET}, rd);
    apb(1'b0, serial_port_pkg::DIV_OFFSET, 32'h0);
    check("div after reset", {16'h0, serial_port_pkg::DEFAULT_DIVISOR}, rd);
    apb(1'b0, serial_port_pkg::STATUS_OFFSET, 32'h0);
    check("init after reset", 32'h0, {31'h0, rd[3]});
    take(serial_port_pkg::CHAR_XON);
    final_report();
  end
endmodule
`default_nettype wire
